//--- verilog/alarm_pin_pkg.sv
// Package: constants and types for alarm pin and reset control
package alarm_pin_pkg;

   // Loss-monitor enable field codes
   typedef enum logic [1:0] {
      LOSS_MON_OFF      = 2'h0,
      LOSS_MON_RESERVED = 2'h1,
      LOSS_MON_SLOW     = 2'h2,
      LOSS_MON_NORMAL   = 2'h3
   } loss_mon_t;

   // Three-level reference strap decode
   typedef enum logic [1:0] {
      REF_CRYSTAL  = 2'h0,
      REF_EXTERNAL = 2'h1,
      REF_RESERVED = 2'h2
   } ref_src_t;

   // Strap level codes as sampled from the three-level pin
   localparam logic [1:0] STRAP_LOW  = 2'h0;
   localparam logic [1:0] STRAP_MID  = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;
   // Edges after reset release until the strap capture closes
   localparam logic [1:0] STRAP_DONE = 2'h3;

   // Reset values of configuration bits
   localparam logic      IRQ_PIN_SELECT_RST = 1'h0;
   localparam logic      IRQ_POLARITY_RST   = 1'h0;
   localparam logic      IN1_SELECT_RST     = 1'h0;
   localparam logic      IN2_SELECT_RST     = 1'h0;
   localparam logic      ALARM_POLARITY_RST = 1'h0;
   localparam loss_mon_t LOSS_MON_RST       = LOSS_MON_NORMAL;
   localparam ref_src_t  REF_SRC_RST        = REF_CRYSTAL;

endpackage : alarm_pin_pkg

//--- verilog/alarm_pin_driver.sv
// Module: one status pin with function select, polarity and tristate
`timescale 1ns/1ps
module alarm_pin_driver
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // Function inputs
   input  wire logic func_a_sel_i,
   input  wire logic func_a_i,
   input  wire logic func_a_pol_i,
   input  wire logic func_b_sel_i,
   input  wire logic func_b_i,
   input  wire logic func_b_pol_i,
   input  wire logic hold_off_i,
   // Pin
   output logic      pin_o,
   output logic      pin_oe_o
);

   logic pin_reg;
   logic pin_next;
   logic oe_reg;
   logic oe_next;

   // Choose function, then polarity, then tristate
   always_comb
   begin
      pin_next = 1'b0;
      oe_next  = 1'b0;
      if (func_a_sel_i)
      begin
         pin_next = func_a_i ^ func_a_pol_i;
         oe_next  = 1'b1;
      end
      else if (func_b_sel_i)
      begin
         pin_next = func_b_i ^ func_b_pol_i;
         oe_next  = 1'b1;
      end
      if (hold_off_i)
      begin
         oe_next = 1'b0;
      end
   end

   // Pin registers
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pin_reg <= 1'b0;
         oe_reg  <= 1'b0;
      end
      else
      begin
         pin_reg <= pin_next;
         oe_reg  <= oe_next;
      end
   end

   assign pin_o    = pin_reg;
   assign pin_oe_o = oe_reg;

endmodule : alarm_pin_driver

//--- verilog/alarm_pin_and_reset_control.sv
// Module: status pin control, external reset and reference strap
`timescale 1ns/1ps
module alarm_pin_and_reset_control
   import alarm_pin_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   // External reset pin, active low
   input  wire logic                    ext_reset_n_i,
   // Configuration
   input  wire logic                    irq_pin_select_i,
   input  wire logic                    irq_polarity_i,
   input  wire logic                    in1_alarm_pin_select_i,
   input  wire logic                    in2_alarm_pin_select_i,
   input  wire logic                    alarm_polarity_i,
   input  wire alarm_pin_pkg::loss_mon_t in1_loss_monitor_enable_i,
   input  wire alarm_pin_pkg::loss_mon_t in2_loss_monitor_enable_i,
   input  wire logic                    cfg_load_i,
   input  wire logic                    outputs_programmed_i,
   // Status events
   input  wire logic                    irq_event_i,
   input  wire logic                    in1_loss_raw_i,
   input  wire logic                    in2_loss_raw_i,
   // Reference strap
   input  wire logic [1:0]              ref_strap_i,
   // Pins
   output logic                         irq_or_in1_alarm_pin_o,
   output logic                         irq_or_in1_alarm_pin_oe_o,
   output logic                         in2_alarm_pin_o,
   output logic                         in2_alarm_pin_oe_o,
   output logic                         clk_out_oe_o,
   output logic                         in_reset_o,
   // Status
   output alarm_pin_pkg::ref_src_t      ref_source_o,
   output logic                         in1_monitor_slow_o,
   output logic                         in2_monitor_slow_o
);
   import alarm_pin_pkg::*;

   // ********************************************************
   // Decode functions
   // ********************************************************

   // Loss monitor active for codes 10 and 11 only
   function automatic logic monitor_on(input loss_mon_t code);
      monitor_on = (code == LOSS_MON_SLOW) || (code == LOSS_MON_NORMAL);
   endfunction : monitor_on

   // ********************************************************
   // Input synchronisers
   // ********************************************************

   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [5:0] raw_in;

   assign raw_in = {ref_strap_i, in2_loss_raw_i, in1_loss_raw_i, irq_event_i, ext_reset_n_i};

   // Two flops per pin input
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_reg <= 6'h01;
         sync2_reg <= 6'h01;
      end
      else
      begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   logic       rst_pin_n;
   logic       irq_sync;
   logic       los1_sync;
   logic       in2_alarm_pin_sync;
   logic [1:0] strap_sync;

   assign rst_pin_n  = sync2_reg[0];
   assign irq_sync   = sync2_reg[1];
   assign los1_sync  = sync2_reg[2];
   assign in2_alarm_pin_sync  = sync2_reg[3];
   assign strap_sync = sync2_reg[5:4];

   // ********************************************************
   // Configuration registers
   // ********************************************************

   logic      irq_sel_reg,   irq_sel_next;
   logic      irq_pol_reg,   irq_pol_next;
   logic      in1_sel_reg,   in1_sel_next;
   logic      in2_sel_reg,   in2_sel_next;
   logic      al_pol_reg,    al_pol_next;
   logic      prog_reg,      prog_next;
   loss_mon_t mon1_reg,      mon1_next;
   loss_mon_t mon2_reg,      mon2_next;
   ref_src_t  ref_reg,       ref_next;
   logic      rst_reg,       rst_next;
   logic [1:0] strap_cap_reg, strap_cap_next;

   // Next-state: defaults while pin reset held, else load
   always_comb
   begin
      irq_sel_next   = irq_sel_reg;
      irq_pol_next   = irq_pol_reg;
      in1_sel_next   = in1_sel_reg;
      in2_sel_next   = in2_sel_reg;
      al_pol_next    = al_pol_reg;
      mon1_next      = mon1_reg;
      mon2_next      = mon2_reg;
      prog_next      = prog_reg;
      ref_next       = ref_reg;
      strap_cap_next = strap_cap_reg;
      rst_next       = !rst_pin_n;
      if (!rst_pin_n)
      begin
         irq_sel_next   = IRQ_PIN_SELECT_RST;
         irq_pol_next   = IRQ_POLARITY_RST;
         in1_sel_next   = IN1_SELECT_RST;
         in2_sel_next   = IN2_SELECT_RST;
         al_pol_next    = ALARM_POLARITY_RST;
         mon1_next      = LOSS_MON_RST;
         mon2_next      = LOSS_MON_RST;
         prog_next      = 1'b0;
         strap_cap_next = 2'h0;
      end
      else
      begin
         if (cfg_load_i)
         begin
            irq_sel_next = irq_pin_select_i;
            irq_pol_next = irq_polarity_i;
            in1_sel_next = in1_alarm_pin_select_i;
            in2_sel_next = in2_alarm_pin_select_i;
            al_pol_next  = alarm_polarity_i;
            mon1_next    = in1_loss_monitor_enable_i;
            mon2_next    = in2_loss_monitor_enable_i;
            prog_next    = outputs_programmed_i;
         end
         // Strap followed until the synchroniser holds the pin level
         if (strap_cap_reg != STRAP_DONE)
         begin
            strap_cap_next = strap_cap_reg + 2'h1;
            case (strap_sync)
               STRAP_LOW:  ref_next = REF_CRYSTAL;
               STRAP_MID:  ref_next = REF_EXTERNAL;
               STRAP_HIGH: ref_next = REF_RESERVED;
               default:    ref_next = REF_RESERVED;
            endcase
         end
      end
   end

   // Configuration flops
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_sel_reg   <= IRQ_PIN_SELECT_RST;
         irq_pol_reg   <= IRQ_POLARITY_RST;
         in1_sel_reg   <= IN1_SELECT_RST;
         in2_sel_reg   <= IN2_SELECT_RST;
         al_pol_reg    <= ALARM_POLARITY_RST;
         mon1_reg      <= LOSS_MON_RST;
         mon2_reg      <= LOSS_MON_RST;
         prog_reg      <= 1'b0;
         ref_reg       <= REF_SRC_RST;
         rst_reg       <= 1'b1;
         strap_cap_reg <= 2'h0;
      end
      else
      begin
         irq_sel_reg   <= irq_sel_next;
         irq_pol_reg   <= irq_pol_next;
         in1_sel_reg   <= in1_sel_next;
         in2_sel_reg   <= in2_sel_next;
         al_pol_reg    <= al_pol_next;
         mon1_reg      <= mon1_next;
         mon2_reg      <= mon2_next;
         prog_reg      <= prog_next;
         ref_reg       <= ref_next;
         rst_reg       <= rst_next;
         strap_cap_reg <= strap_cap_next;
      end
   end

   // ********************************************************
   // Status outputs
   // ********************************************************

   logic oe_reg, oe_next;
   logic slow1_reg, slow1_next;
   logic slow2_reg, slow2_next;

   // Clock outputs off during reset and until programmed
   always_comb
   begin
      oe_next    = prog_reg && rst_pin_n && !rst_reg;
      slow1_next = (mon1_reg == LOSS_MON_SLOW);
      slow2_next = (mon2_reg == LOSS_MON_SLOW);
   end

   // Status flops
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         oe_reg    <= 1'b0;
         slow1_reg <= 1'b0;
         slow2_reg <= 1'b0;
      end
      else
      begin
         oe_reg    <= oe_next;
         slow1_reg <= slow1_next;
         slow2_reg <= slow2_next;
      end
   end

   assign clk_out_oe_o       = oe_reg;
   assign in_reset_o         = rst_reg;
   assign ref_source_o       = ref_reg;
   assign in1_monitor_slow_o = slow1_reg;
   assign in2_monitor_slow_o = slow2_reg;

   // ********************************************************
   // Pin drivers
   // ********************************************************

   logic los1_masked;
   logic in2_alarm_pin_masked;

   // Loss alarm only when monitor enabled
   assign los1_masked = los1_sync && monitor_on(mon1_reg);
   assign in2_alarm_pin_masked = in2_alarm_pin_sync && monitor_on(mon2_reg);

   // Shared pin: interrupt has priority over input one alarm
   alarm_pin_driver u_shared_pin
   (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .func_a_sel_i (irq_sel_reg),
      .func_a_i     (irq_sync),
      .func_a_pol_i (!irq_pol_reg),
      .func_b_sel_i (in1_sel_reg),
      .func_b_i     (los1_masked),
      .func_b_pol_i (!al_pol_reg),
      .hold_off_i   (1'b0),
      .pin_o        (irq_or_in1_alarm_pin_o),
      .pin_oe_o     (irq_or_in1_alarm_pin_oe_o)
   );

   // Second pin: input two alarm only
   alarm_pin_driver u_in2_pin
   (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .func_a_sel_i (in2_sel_reg),
      .func_a_i     (in2_alarm_pin_masked),
      .func_a_pol_i (!al_pol_reg),
      .func_b_sel_i (1'b0),
      .func_b_i     (1'b0),
      .func_b_pol_i (1'b0),
      .hold_off_i   (1'b0),
      .pin_o        (in2_alarm_pin_o),
      .pin_oe_o     (in2_alarm_pin_oe_o)
   );

endmodule : alarm_pin_and_reset_control

//--- sim/alarm_pin_checker_assertions.sv
// Checker: port-level properties of the alarm pin and reset control block
`timescale 1ns/1ps
module alarm_pin_checker
   import alarm_pin_pkg::*;
(
   // Clock and reset
   input wire logic                     clk_i,
   input wire logic                     reset_i,
   // Inputs
   input wire logic                     ext_reset_n_i,
   input wire logic                     irq_pin_select_i,
   input wire logic                     irq_polarity_i,
   input wire logic                     in1_alarm_pin_select_i,
   input wire logic                     in2_alarm_pin_select_i,
   input wire logic                     alarm_polarity_i,
   input wire alarm_pin_pkg::loss_mon_t in1_loss_monitor_enable_i,
   input wire alarm_pin_pkg::loss_mon_t in2_loss_monitor_enable_i,
   input wire logic                     cfg_load_i,
   input wire logic                     outputs_programmed_i,
   input wire logic                     irq_event_i,
   input wire logic                     in1_loss_raw_i,
   input wire logic                     in2_loss_raw_i,
   input wire logic [1:0]               ref_strap_i,
   // Outputs
   input wire logic                     irq_or_in1_alarm_pin_o,
   input wire logic                     irq_or_in1_alarm_pin_oe_o,
   input wire logic                     in2_alarm_pin_o,
   input wire logic                     in2_alarm_pin_oe_o,
   input wire logic                     clk_out_oe_o,
   input wire logic                     in_reset_o,
   input wire alarm_pin_pkg::ref_src_t  ref_source_o,
   input wire logic                     in1_monitor_slow_o,
   input wire logic                     in2_monitor_slow_o
);
   // ****
   // Settle tracking
   // ****
   logic [15:0] vec;
   logic [15:0] vec_reg;
   logic        ok_reg;
   logic [3:0]  n_reg;
   logic        s;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Snapshot of all inputs that shape the pins
   assign vec = {irq_pin_select_i, irq_polarity_i, in1_alarm_pin_select_i,
      in2_alarm_pin_select_i, alarm_polarity_i, in1_loss_monitor_enable_i,
      in2_loss_monitor_enable_i, outputs_programmed_i, irq_event_i, in1_loss_raw_i,
      in2_loss_raw_i, ref_strap_i, ext_reset_n_i};
   // Load taken with inputs steady, and cycles since it
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         vec_reg <= 16'h0;
         ok_reg  <= 1'h0;
         n_reg   <= 4'h0;
      end
      else
      begin
         vec_reg <= vec;
         if (vec != vec_reg || !ext_reset_n_i)
            ok_reg <= 1'h0;
         else if (cfg_load_i)
            ok_reg <= 1'h1;
         n_reg <= cfg_load_i ? 4'h0 : (n_reg == 4'hf ? n_reg : n_reg + 4'h1);
      end
   end
   // Settled only while the inputs still match the last cycle
   assign s = ok_reg && n_reg >= 4'h4 && vec == vec_reg;
   property p_irq;
      s && irq_pin_select_i |-> irq_or_in1_alarm_pin_oe_o
         && irq_or_in1_alarm_pin_o == (irq_event_i ^ !irq_polarity_i);
   endproperty
   a_irq: assert property (p_irq) else $error("shared pin irq level wrong");
   property p_in1;
      s && !irq_pin_select_i && in1_alarm_pin_select_i |-> irq_or_in1_alarm_pin_oe_o
         && irq_or_in1_alarm_pin_o == ((in1_loss_raw_i & in1_loss_monitor_enable_i[1])
         ^ !alarm_polarity_i);
   endproperty
   a_in1: assert property (p_in1) else $error("shared pin alarm level wrong");
   property p_tri1;
      s && !irq_pin_select_i && !in1_alarm_pin_select_i |-> !irq_or_in1_alarm_pin_oe_o;
   endproperty
   a_tri1: assert property (p_tri1) else $error("shared pin driven unselected");
   property p_in2;
      s && in2_alarm_pin_select_i |-> in2_alarm_pin_oe_o && in2_alarm_pin_o ==
         ((in2_loss_raw_i & in2_loss_monitor_enable_i[1]) ^ !alarm_polarity_i);
   endproperty
   a_in2: assert property (p_in2) else $error("second pin level wrong");
   property p_tri2;
      s && !in2_alarm_pin_select_i |-> !in2_alarm_pin_oe_o;
   endproperty
   a_tri2: assert property (p_tri2) else $error("second pin driven unselected");
   property p_slow;
      s |-> in1_monitor_slow_o == (in1_loss_monitor_enable_i == LOSS_MON_SLOW)
         && in2_monitor_slow_o == (in2_loss_monitor_enable_i == LOSS_MON_SLOW);
   endproperty
   a_slow: assert property (p_slow) else $error("slow monitor flag wrong");
   property p_ext;
      !ext_reset_n_i [*6] |-> in_reset_o && !clk_out_oe_o && !in2_alarm_pin_oe_o
         && !irq_or_in1_alarm_pin_oe_o;
   endproperty
   a_ext: assert property (p_ext) else $error("outputs active in reset");
   property p_clk;
      s |-> clk_out_oe_o == outputs_programmed_i;
   endproperty
   a_clk: assert property (p_clk) else $error("clock enable wrong");
   property p_ref;
      s |-> ref_source_o == (ref_strap_i == STRAP_LOW ? REF_CRYSTAL :
         ref_strap_i == STRAP_MID ? REF_EXTERNAL : REF_RESERVED);
   endproperty
   a_ref: assert property (p_ref) else $error("reference source wrong");
   c_irq: cover property (s && irq_pin_select_i && irq_event_i);
   c_in2: cover property (s && in2_alarm_pin_select_i && in2_loss_raw_i);
   c_ext: cover property (!ext_reset_n_i [*6]);
endmodule : alarm_pin_checker

bind alarm_pin_and_reset_control alarm_pin_checker u_chk (.*);

//--- sim/board_ctrl_model.sv
// Partner model: board controller driving reset and watching the status pins
`timescale 1ns/1ps
module board_ctrl_model
(
   // Clock and request
   input  wire logic       clk_i,
   input  wire logic       hold_rst_i,
   // Status pins of the device
   input  wire logic [1:0] pin_i,
   input  wire logic [1:0] pin_oe_i,
   // Reset pin and board levels
   output logic            ext_reset_n_o,
   output logic [1:0]      seen_o
);
   // ****
   // Board side
   // ****
   logic [1:0] last_reg = 2'h0;
   // Reset pin low on request, pulled up otherwise
   assign ext_reset_n_o = !hold_rst_i;
   // Released pin shows the inverse of its last driven level
   always @(posedge clk_i)
      last_reg <= (pin_oe_i & pin_i) | (~pin_oe_i & last_reg);
   assign seen_o = (pin_oe_i & pin_i) | (~pin_oe_i & ~last_reg);
endmodule : board_ctrl_model

//--- sim/tb_alarm_pin_and_reset_control.sv
// Testbench: self-checking run of the alarm pin and reset control block
`timescale 1ns/1ps
module tb_alarm_pin_and_reset_control;
   import alarm_pin_pkg::*;
   // ****
   // Signals
   // ****
   logic       clk_i = 1'h0;
   logic       reset_i = 1'h1;
   logic       hold = 1'h0;
   logic       ext_n;
   logic [5:0] cf = 6'h0;
   logic [1:0] m1 = 2'h3;
   logic [1:0] m2 = 2'h3;
   logic [2:0] ev = 3'h0;
   logic [1:0] strap = 2'h0;
   logic       ld = 1'h0;
   logic [1:0] pin;
   logic [1:0] oe;
   logic [1:0] seen;
   logic       coe;
   logic       inr;
   ref_src_t   rs;
   logic       s1;
   logic       s2;
   int         miscompares = 0;
   int         n_tests = 0;
   // Clock
   always #12.5 clk_i = ~clk_i;
   alarm_pin_and_reset_control uut (.clk_i(clk_i), .reset_i(reset_i), .ext_reset_n_i(ext_n),
      .irq_pin_select_i(cf[5]), .irq_polarity_i(cf[4]), .in1_alarm_pin_select_i(cf[3]),
      .in2_alarm_pin_select_i(cf[2]), .alarm_polarity_i(cf[1]),
      .in1_loss_monitor_enable_i(loss_mon_t'(m1)), .in2_loss_monitor_enable_i(loss_mon_t'(m2)),
      .cfg_load_i(ld), .outputs_programmed_i(cf[0]), .irq_event_i(ev[2]),
      .in1_loss_raw_i(ev[1]), .in2_loss_raw_i(ev[0]), .ref_strap_i(strap),
      .irq_or_in1_alarm_pin_o(pin[0]), .irq_or_in1_alarm_pin_oe_o(oe[0]),
      .in2_alarm_pin_o(pin[1]), .in2_alarm_pin_oe_o(oe[1]), .clk_out_oe_o(coe),
      .in_reset_o(inr), .ref_source_o(rs), .in1_monitor_slow_o(s1), .in2_monitor_slow_o(s2));
   board_ctrl_model board (.clk_i(clk_i), .hold_rst_i(hold), .pin_i(pin), .pin_oe_i(oe),
      .ext_reset_n_o(ext_n), .seen_o(seen));
   // ****
   // Tasks
   // ****
   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic load;
      repeat (4) @(posedge clk_i);
      ld <= 1'h1;
      @(posedge clk_i);
      ld <= 1'h0;
      repeat (5) @(posedge clk_i);
      #1;
   endtask : load
   task automatic ext_pulse;
      @(posedge clk_i);
      hold <= 1'h1;
      repeat (8) @(posedge clk_i);
      #1;
      chk("in_reset", 1, inr);
      chk("rst_pins", 0, {oe, coe});
      @(posedge clk_i);
      ld <= 1'h1;
      @(posedge clk_i);
      ld <= 1'h0;
      hold <= 1'h0;
   endtask : ext_pulse
   task automatic t_idle;
      chk("idle", 0, {oe, coe});
      chk("ref", REF_CRYSTAL, rs);
   endtask : t_idle
   task automatic t_shared;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk_i);
         cf <= {i[0], i[2], i[1], 1'h0, i[2], 1'h1};
         ev <= {i[3], !i[3], 1'h0};
         load();
         chk("shared_oe", i[1:0] != 0, oe[0]);
         if (i[0]) chk("irq", i[3] ^ !i[2], seen[0]);
         else if (i[1]) chk("in1", !i[3] ^ !i[2], seen[0]);
      end
   endtask : t_shared
   task automatic t_in2;
      for (int i = 0; i < 16; i++)
      begin
         logic r;
         r = !(i[3] & i[1] & i[0]);
         @(posedge clk_i);
         cf <= {3'h0, i[2], i[3], 1'h1};
         m1 <= i[1:0];
         m2 <= i[1:0];
         ev <= {2'h0, r};
         load();
         chk("in2_oe", i[2], oe[1]);
         if (i[2]) chk("in2", (r & i[1]) ^ !i[3], seen[1]);
         chk("slow", {2{i[1:0] == 2'h2}}, {s1, s2});
      end
   endtask : t_in2
   task automatic t_ext;
      @(posedge clk_i);
      cf <= 6'h07;
      load();
      chk("clk_oe", 1, coe);
      ext_pulse();
      repeat (6) @(posedge clk_i);
      #1;
      chk("after", 0, {oe, coe, inr});
   endtask : t_ext
   task automatic t_strap;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         strap <= i[1:0];
         ext_pulse();
         load();
         chk("strap", i == 0 ? REF_CRYSTAL : i == 1 ? REF_EXTERNAL : REF_RESERVED, rs);
      end
   endtask : t_strap
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      #1;
      t_idle();
      t_shared();
      t_in2();
      t_ext();
      t_strap();
      report_and_stop();
   end
   // Watchdog
   initial
   begin
      #(25 * 2000);
      miscompares++;
      report_and_stop();
   end
endmodule : tb_alarm_pin_and_reset_control
